// >>> dv/test_wgs_core.sv
// Self-checking bench for the generator shutdown control core.
// Assumes wgs_pkg, wgs_core and the bridge model compile first.
`timescale 1ns/1ns
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin \
   mismatches++; $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); \
   end end
module test_wgs_core;
   logic       sys_clk_i   = 1'b0;
   logic       rst_b_i     = 1'b0;
   logic [3:0] addr        = 4'h0;
   logic [7:0] wdata       = 8'h00;
   logic       wr          = 1'b0;
   logic       rd          = 1'b0;
   logic       win         = 1'b0;
   logic [3:0] sd_b        = 4'hF;
   logic       src_act     = 1'b0;
   logic       rd_seen     = 1'b0;
   logic [7:0] rdata;
   logic [3:0] wave;
   logic [3:0] oe;
   logic [3:0] pin;
   logic [5:0] dbr;
   logic [5:0] dbf;
   logic       keep;
   logic [5:0] rnd;
   logic [7:0] e_now;
   logic [7:0] exp_q[$];
   int         mismatches  = 0;
   int         check_count = 0;
   int         cycles      = 0;

   always #50 sys_clk_i = ~sys_clk_i;

   wgs_core uut (
      .sys_clk_i          (sys_clk_i),
      .rst_b_i            (rst_b_i),
      .reg_addr_i         (addr),
      .reg_wdata_i        (wdata),
      .reg_wr_i           (wr),
      .reg_rd_i           (rd),
      .reg_rdata_o        (rdata),
      .wave_in_i          (win),
      .shutdown_in_b_i    (sd_b),
      .input_src_active_i (src_act),
      .wave_o             (wave),
      .wave_oe_o          (oe),
      .db_rise_o          (dbr),
      .db_fall_o          (dbf),
      .fast_osc_keep_o    (keep)
   );

   wgs_bridge_model u_bridge (
      .wave_i    (wave),
      .wave_oe_i (oe),
      .gate_o    (pin)
   );

   // ****************************************
   // Bus tasks and result monitor
   // ****************************************
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask

   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge sys_clk_i);
      wr    <= 1'b0;
   endtask

   task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
      @(posedge sys_clk_i);
      addr <= a;
      rd   <= 1'b1;
      exp_q.push_back(e);
      @(posedge sys_clk_i);
      rd   <= 1'b0;
   endtask

   task automatic chk_wave(input logic [3:0] e);
      @(negedge sys_clk_i);
      `CHK(wave, e)
   endtask

   // Read data is checked in the cycle after the strobe and holds until the next read
   always @(posedge sys_clk_i) begin
      if (rd_seen) begin
         e_now = exp_q.pop_front();
         `CHK(rdata, e_now)
      end
      rd_seen <= rd;
   end

   task automatic final_report();
      $display("Checks: %0d  mismatches: %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         final_report();
      end
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      void'($urandom(70));
      rnd = 6'($urandom());
      cyc(2);
      rst_b_i <= 1'b1;
      cyc(3);
      rd_reg(wgs_pkg::ADDR_CTRL_ZERO, 8'h00);
      rd_reg(wgs_pkg::ADDR_SD_CTRL, 8'h00);
      rd_reg(4'h9, 8'h00);
      // Disabled: buffer loads straight away, load bit refused
      wr_reg(wgs_pkg::ADDR_DB_RISE, {2'b00, rnd});
      wr_reg(wgs_pkg::ADDR_DB_FALL, {2'b00, ~rnd});
      cyc(1);
      `CHK(dbr, rnd)
      `CHK(dbf, ~rnd)
      wr_reg(wgs_pkg::ADDR_CTRL_ZERO, 8'h44);
      rd_reg(wgs_pkg::ADDR_CTRL_ZERO, 8'h04);
      // Configuration in the required order, shutdown source selected and shutdown set first
      wr_reg(wgs_pkg::ADDR_SD_SRC, 8'hF1);
      wr_reg(wgs_pkg::ADDR_SD_CTRL, 8'hA4);
      wr_reg(wgs_pkg::ADDR_POLARITY, 8'h0F);
      wr_reg(wgs_pkg::ADDR_OUT_EN, 8'h0F);
      wr_reg(wgs_pkg::ADDR_CLK_SEL, 8'h01);
      chk_wave(4'h9);
      `CHK(oe, 4'h0)
      wr_reg(wgs_pkg::ADDR_CTRL_ZERO, 8'hC4);
      rd_reg(wgs_pkg::ADDR_CTRL_ZERO, 8'h84);
      chk_wave(4'h9);
      `CHK(pin, 4'h9)
      `CHK(keep, 1'b0)
      src_act <= 1'b1;
      cyc(1);
      @(negedge sys_clk_i);
      `CHK(keep, 1'b1)
      for (int m = 0; m < 8; m++) begin
         wr_reg(wgs_pkg::ADDR_CTRL_ZERO, 8'h80 | 8'(m));
         rd_reg(wgs_pkg::ADDR_CTRL_ZERO, 8'h80 | 8'(m));
      end
      wr_reg(wgs_pkg::ADDR_CTRL_ZERO, 8'hBC);
      rd_reg(wgs_pkg::ADDR_CTRL_ZERO, 8'h84);
      // Enabled: new value waits for load request and input edge
      wr_reg(wgs_pkg::ADDR_DB_RISE, {2'b00, ~rnd});
      wr_reg(wgs_pkg::ADDR_DB_FALL, {2'b00, rnd});
      cyc(1);
      `CHK(dbr, rnd)
      `CHK(dbf, ~rnd)
      wr_reg(wgs_pkg::ADDR_CTRL_ZERO, 8'hC4);
      rd_reg(wgs_pkg::ADDR_CTRL_ZERO, 8'hC4);
      win <= 1'b1;
      cyc(6);
      `CHK(dbr, ~rnd)
      `CHK(dbf, rnd)
      rd_reg(wgs_pkg::ADDR_CTRL_ZERO, 8'h84);
      // Software restart refused while a selected source is low
      wr_reg(wgs_pkg::ADDR_POLARITY, 8'h00);
      sd_b <= 4'hE;
      cyc(5);
      wr_reg(wgs_pkg::ADDR_SD_CTRL, 8'h24);
      rd_reg(wgs_pkg::ADDR_SD_CTRL, 8'hA4);
      sd_b <= 4'hF;
      cyc(5);
      wr_reg(wgs_pkg::ADDR_SD_CTRL, 8'h24);
      rd_reg(wgs_pkg::ADDR_SD_CTRL, 8'h24);
      chk_wave(4'h9);
      win <= 1'b0;
      cyc(5);
      win <= 1'b1;
      cyc(6);
      chk_wave(4'h5);
      // Source override lands with no clock edge
      @(posedge sys_clk_i);
      sd_b <= 4'hE;
      #1;
      `CHK(wave, 4'h9)
      // Automatic restart once all sources go high
      wr_reg(wgs_pkg::ADDR_SD_CTRL, 8'h64);
      rd_reg(wgs_pkg::ADDR_SD_CTRL, 8'hE4);
      sd_b <= 4'hF;
      cyc(6);
      rd_reg(wgs_pkg::ADDR_SD_CTRL, 8'h64);
      chk_wave(4'h9);
      win <= 1'b0;
      cyc(5);
      win <= 1'b1;
      cyc(6);
      chk_wave(4'h5);
      // Software set of shutdown with restart off
      wr_reg(wgs_pkg::ADDR_SD_CTRL, 8'h84);
      cyc(2);
      chk_wave(4'h1);
      win <= 1'b0;
      cyc(5);
      win <= 1'b1;
      cyc(6);
      chk_wave(4'h1);
      // Second reset in mid-run
      rst_b_i <= 1'b0;
      cyc(2);
      rst_b_i <= 1'b1;
      cyc(3);
      rd_reg(wgs_pkg::ADDR_CTRL_ZERO, 8'h00);
      `CHK(oe, 4'h0)
      cyc(4);
      final_report();
   end
endmodule

// >>> dv/wgs_bridge_model.sv
// Model of the external bridge gate drivers on the generator outputs.
// Assumes pull-downs on the driver inputs, so an undriven pin reads 0.
`timescale 1ns/1ns
module wgs_bridge_model (
   input  wire logic [3:0] wave_i,
   input  wire logic [3:0] wave_oe_i,
   output logic      [3:0] gate_o
);
   // ****************************************
   // Pin level seen by the gate drivers
   // ****************************************
   // Released pin falls to the pull-down level
   assign gate_o = wave_i & wave_oe_i;
endmodule

// >>> verilog/wgs_core.sv
// Control side of a complementary waveform generator with shutdown.
// Assumes a register master on sys_clk_i and external bridge drivers.
//
// Functional notes
// [RL1] Generator keeps running in sleep while its clock and input live.
// [RL2] Fast oscillator kept awake when enabled, input active, selected.
// [RL3] Software keeps pins as inputs until enable is set.
// [RL4] Software clears enable, configures everything, then sets enable.
// [RL5] Software sets overrides and shutdown, clears auto-restart first.
// [RL6] Software starts by setting auto-restart or clearing shutdown.
// [RL7] Two-bit override fields give levels for B/D and A/C.
// [RL8] Polarity does not change the override levels.
// [RL9] Auto-restart bit picks software or automatic restart.
// [RL10] Software clear of shutdown works only with all selected sources high.
// [RL11] Auto-restart clears shutdown once all selected sources are high.
// [RL12] Overrides hold until the first input rising edge after clear.
// [RL13] Control bit 7 enables the module.
// [RL14] Bit 6 loads dead-band buffers at next input edge, self-clears.
// [RL15] Load bit settable only when already enabled.
// [RL16] Mode field bits 2-0 select the output mode.
// [RL17] Control bits 5-3 read zero.
// [RL18] Control bits reset to zero.
// [RL19] Shutdown inputs are active-low levels, block clearing.
// [RL20] Software set of shutdown forces the shutdown state.
// [RL21] Shutdown entry overrides outputs without a clock edge.
`timescale 1ns/1ns
module wgs_core (
   input  wire logic        sys_clk_i,
   input  wire logic        rst_b_i,
   input  wire logic [3:0]  reg_addr_i,
   input  wire logic [7:0]  reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic      [7:0]  reg_rdata_o,
   input  wire logic        wave_in_i,
   input  wire logic [3:0]  shutdown_in_b_i,
   input  wire logic        input_src_active_i,
   output logic      [3:0]  wave_o,
   output logic      [3:0]  wave_oe_o,
   output logic      [5:0]  db_rise_o,
   output logic      [5:0]  db_fall_o,
   output logic             fast_osc_keep_o
);

   // ****************************************
   // Reset release
   // ****************************************
   logic [1:0] rst_sync_reg;
   logic [1:0] rst_sync_next;
   logic       rst_n;

   always_comb begin
      rst_sync_next = {rst_sync_reg[0], 1'b1};
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_sync_reg <= 2'h0;
      end else begin
         rst_sync_reg <= rst_sync_next;
      end
   end

   assign rst_n = rst_sync_reg[1];

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic       in_s;
   logic [3:0] sd_b_s;

   wgs_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_in_sync (
      .clk_i   (sys_clk_i),
      .rst_n_i (rst_n),
      .d_i     (wave_in_i),
      .q_o     (in_s)
   );

   wgs_sync #(.WIDTH(4), .RST_VAL(4'hF)) u_sd_sync (
      .clk_i   (sys_clk_i),
      .rst_n_i (rst_n),
      .d_i     (shutdown_in_b_i),
      .q_o     (sd_b_s)
   );

   // ****************************************
   // Register file
   // ****************************************
   logic                     en_reg, en_next;
   logic                     ld_reg, ld_next;
   logic [2:0]               mode_reg, mode_next;
   logic [3:0]               pol_reg, pol_next;
   wgs_pkg::wgs_sd_ctrl_type sdc_reg, sdc_next;
   wgs_pkg::wgs_sd_src_type  sds_reg, sds_next;
   logic [5:0]               dbr_buf_reg, dbr_buf_next;
   logic [5:0]               dbf_buf_reg, dbf_buf_next;
   logic [5:0]               dbr_act_reg, dbr_act_next;
   logic [5:0]               dbf_act_reg, dbf_act_next;
   logic [3:0]               oe_reg, oe_next;
   logic                     clk_fast_reg, clk_fast_next;
   logic                     hold_reg, hold_next;
   logic                     in_d_reg, in_d_next;
   logic                     pp_reg, pp_next;
   logic [3:0]               wave_reg, wave_next;
   logic [7:0]               rdata_reg, rdata_next;
   logic                     wr_ctrl, wr_sdc, rise, fall, src_act;
   logic [3:0]               norm;

   assign wr_ctrl = reg_wr_i && (reg_addr_i == wgs_pkg::ADDR_CTRL_ZERO);
   assign wr_sdc  = reg_wr_i && (reg_addr_i == wgs_pkg::ADDR_SD_CTRL);
   assign rise    = in_s && !in_d_reg;
   assign fall    = !in_s && in_d_reg;
   // Selected shutdown sources, active low
   assign src_act = |(sds_reg.source_sel & ~sd_b_s); // RL19

   always_comb begin
      en_next       = en_reg;
      ld_next       = ld_reg;
      mode_next     = mode_reg;
      pol_next      = pol_reg;
      sdc_next      = sdc_reg;
      sds_next      = sds_reg;
      dbr_buf_next  = dbr_buf_reg;
      dbf_buf_next  = dbf_buf_reg;
      dbr_act_next  = dbr_act_reg;
      dbf_act_next  = dbf_act_reg;
      oe_next       = oe_reg;
      clk_fast_next = clk_fast_reg;
      if (ld_reg && (rise || fall)) begin
         dbr_act_next = dbr_buf_reg; // RL14
         dbf_act_next = dbf_buf_reg;
         ld_next      = 1'b0;
      end
      if (!en_reg) begin
         ld_next = 1'b0;
      end
      if (wr_ctrl) begin
         en_next   = reg_wdata_i[wgs_pkg::CTRL_EN_BIT]; // RL13
         mode_next = reg_wdata_i[2:0]; // RL16
         // Set wins over the hardware clear
         if (en_reg && reg_wdata_i[wgs_pkg::CTRL_EN_BIT] &&
             reg_wdata_i[wgs_pkg::CTRL_LD_BIT]) begin
            ld_next = 1'b1; // RL15
         end else if (!reg_wdata_i[wgs_pkg::CTRL_EN_BIT]) begin
            ld_next = 1'b0;
         end
      end
      if (reg_wr_i) begin
         case (reg_addr_i)
            wgs_pkg::ADDR_POLARITY: pol_next = reg_wdata_i[3:0];
            wgs_pkg::ADDR_SD_SRC:   sds_next = reg_wdata_i;
            wgs_pkg::ADDR_DB_RISE: begin
               dbr_buf_next = reg_wdata_i[5:0];
               if (!en_reg) begin
                  dbr_act_next = reg_wdata_i[5:0];
               end
            end
            wgs_pkg::ADDR_DB_FALL: begin
               dbf_buf_next = reg_wdata_i[5:0];
               if (!en_reg) begin
                  dbf_act_next = reg_wdata_i[5:0];
               end
            end
            wgs_pkg::ADDR_OUT_EN:   oe_next = reg_wdata_i[3:0];
            wgs_pkg::ADDR_CLK_SEL:  clk_fast_next = reg_wdata_i[0];
            default: begin
            end
         endcase
      end
      // Shutdown bit: auto clear, then software, then hardware set
      if (sdc_reg.auto_restart && !src_act) begin
         sdc_next.shutdown = 1'b0; // RL9 RL11
      end
      if (wr_sdc) begin
         sdc_next.auto_restart       = reg_wdata_i[6];
         sdc_next.override_level_b_d = reg_wdata_i[5:4];
         sdc_next.override_level_a_c = reg_wdata_i[3:2];
         if (reg_wdata_i[wgs_pkg::SD_BIT]) begin
            sdc_next.shutdown = 1'b1; // RL20
         end else if (!src_act) begin
            sdc_next.shutdown = 1'b0; // RL10
         end
      end
      if (src_act) begin
         sdc_next.shutdown = 1'b1; // RL19
      end
      sdc_next.unused = 2'h0;
   end

   // ****************************************
   // Waveform and override state
   // ****************************************
   always_comb begin
      in_d_next = in_s;
      pp_next   = rise ? !pp_reg : pp_reg;
      // Overrides stay until first rise after clear
      if (sdc_reg.shutdown) begin
         hold_next = 1'b1; // RL12
      end else if (rise) begin
         hold_next = 1'b0; // RL12
      end else begin
         hold_next = hold_reg;
      end
      case (mode_reg) // RL16
         wgs_pkg::MODE_STEER:      norm = {4{in_s}};
         wgs_pkg::MODE_SYNC_STEER: norm = {4{in_s}};
         wgs_pkg::MODE_FWD_FULL:   norm = {in_s, 1'b0, 1'b0, 1'b1};
         wgs_pkg::MODE_REV_FULL:   norm = {1'b0, 1'b1, in_s, 1'b0};
         wgs_pkg::MODE_HALF:       norm = {!in_s, in_s, !in_s, in_s};
         wgs_pkg::MODE_PUSH_PULL: begin
            norm = {in_s && !pp_reg, in_s && pp_reg,
                    in_s && !pp_reg, in_s && pp_reg};
         end
         default:                  norm = 4'h0;
      endcase
      wave_next = norm ^ pol_reg;
   end

   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         en_reg       <= 1'b0; // RL18
         ld_reg       <= 1'b0;
         mode_reg     <= 3'h0;
         pol_reg      <= 4'h0;
         sdc_reg      <= wgs_pkg::RESET_BYTE;
         sds_reg      <= wgs_pkg::RESET_BYTE;
         dbr_buf_reg  <= 6'h00;
         dbf_buf_reg  <= 6'h00;
         dbr_act_reg  <= 6'h00;
         dbf_act_reg  <= 6'h00;
         oe_reg       <= 4'h0;
         clk_fast_reg <= 1'b0;
         hold_reg     <= 1'b0;
         in_d_reg     <= 1'b0;
         pp_reg       <= 1'b0;
         wave_reg     <= 4'h0;
         rdata_reg    <= wgs_pkg::RESET_BYTE;
      end else begin
         en_reg       <= en_next;
         ld_reg       <= ld_next;
         mode_reg     <= mode_next;
         pol_reg      <= pol_next;
         sdc_reg      <= sdc_next;
         sds_reg      <= sds_next;
         dbr_buf_reg  <= dbr_buf_next;
         dbf_buf_reg  <= dbf_buf_next;
         dbr_act_reg  <= dbr_act_next;
         dbf_act_reg  <= dbf_act_next;
         oe_reg       <= oe_next;
         clk_fast_reg <= clk_fast_next;
         hold_reg     <= hold_next;
         in_d_reg     <= in_d_next;
         pp_reg       <= pp_next;
         wave_reg     <= wave_next;
         rdata_reg    <= rdata_next;
      end
   end

   // ****************************************
   // Read port
   // ****************************************
   always_comb begin
      rdata_next = rdata_reg;
      if (reg_rd_i) begin
         case (reg_addr_i)
            wgs_pkg::ADDR_CTRL_ZERO:
               rdata_next = {en_reg, ld_reg, 3'h0, mode_reg}; // RL17
            wgs_pkg::ADDR_POLARITY: rdata_next = {2'h0, in_s, 1'h0, pol_reg};
            wgs_pkg::ADDR_SD_CTRL:  rdata_next = sdc_reg;
            wgs_pkg::ADDR_SD_SRC:   rdata_next = sds_reg;
            wgs_pkg::ADDR_DB_RISE:  rdata_next = {2'h0, dbr_buf_reg};
            wgs_pkg::ADDR_DB_FALL:  rdata_next = {2'h0, dbf_buf_reg};
            wgs_pkg::ADDR_OUT_EN:   rdata_next = {4'h0, oe_reg};
            wgs_pkg::ADDR_CLK_SEL:  rdata_next = {7'h0, clk_fast_reg};
            default:                rdata_next = wgs_pkg::UNMAPPED_READ;
         endcase
      end
   end

   // ****************************************
   // Output stage
   // ****************************************
   logic       ovr;
   logic [3:0] lvl;

   // Raw pins give immediate override ahead of the synchroniser
   assign ovr = sdc_reg.shutdown || hold_reg ||
                |(sds_reg.source_sel & ~shutdown_in_b_i); // RL21
   // Order A, B, C, D; levels bypass polarity
   assign lvl = {sdc_reg.override_level_b_d[1], sdc_reg.override_level_a_c[1],
                 sdc_reg.override_level_b_d[0],
                 sdc_reg.override_level_a_c[0]}; // RL7 RL8

   genvar g;
   generate
      for (g = 0; g < wgs_pkg::NUM_OUT; g++) begin : g_out
         assign wave_o[g] = (ovr && sds_reg.affected[g]) ? lvl[g]
                                                         : wave_reg[g];
         assign wave_oe_o[g] = en_reg && oe_reg[g]; // RL13
      end
   endgenerate

   assign reg_rdata_o = rdata_reg;
   assign db_rise_o   = dbr_act_reg;
   assign db_fall_o   = dbf_act_reg;
   // Runs on its own clock; sleep does not gate it
   assign fast_osc_keep_o = en_reg && input_src_active_i &&
                            clk_fast_reg; // RL1 RL2

   // ****************************************
   // Assertions
   // ****************************************
   property p_ld_needs_en;
      @(posedge sys_clk_i) disable iff (!rst_n)
      (wr_ctrl && !en_reg) |=> !ld_reg;
   endproperty
   a_ld_needs_en: assert property (p_ld_needs_en) // RL15
      else $error("load bit set in same write as enable");

   property p_ctrl_zero_bits;
      @(posedge sys_clk_i) disable iff (!rst_n)
      (reg_rd_i && reg_addr_i == wgs_pkg::ADDR_CTRL_ZERO)
         |=> (reg_rdata_o[5:3] == 3'h0) && (reg_rdata_o[2:0] == mode_reg);
   endproperty
   a_ctrl_zero_bits: assert property (p_ctrl_zero_bits) // RL17
      else $error("control read wrong");

   property p_sw_clear_blocked;
      @(posedge sys_clk_i) disable iff (!rst_n)
      (wr_sdc && src_act) |=> sdc_reg.shutdown;
   endproperty
   a_sw_clear_blocked: assert property (p_sw_clear_blocked) // RL10
      else $error("shutdown cleared with source active");

   property p_auto_clear;
      @(posedge sys_clk_i) disable iff (!rst_n)
      (sdc_reg.auto_restart && !src_act && !wr_sdc) |=> !sdc_reg.shutdown;
   endproperty
   a_auto_clear: assert property (p_auto_clear) // RL11
      else $error("auto restart did not clear shutdown");

   property p_hold_after_clear;
      @(posedge sys_clk_i) disable iff (!rst_n)
      $fell(sdc_reg.shutdown) |-> hold_reg ##1 (hold_reg || $past(rise));
   endproperty
   a_hold_after_clear: assert property (p_hold_after_clear) // RL12
      else $error("override released before rising edge");

   property p_ld_transfer;
      @(posedge sys_clk_i) disable iff (!rst_n)
      (ld_reg && en_reg && (rise || fall) && !wr_ctrl)
         |=> !ld_reg && (db_rise_o == $past(dbr_buf_reg));
   endproperty
   a_ld_transfer: assert property (p_ld_transfer) // RL14
      else $error("dead-band transfer missing");

   property p_src_sets_sd;
      @(posedge sys_clk_i) disable iff (!rst_n)
      src_act |=> sdc_reg.shutdown;
   endproperty
   a_src_sets_sd: assert property (p_src_sets_sd) // RL19
      else $error("active source did not set shutdown");

   property p_override_level;
      @(posedge sys_clk_i) disable iff (!rst_n)
      (sdc_reg.shutdown && sds_reg.affected[0])
         |-> wave_o[0] == sdc_reg.override_level_a_c[0];
   endproperty
   a_override_level: assert property (p_override_level) // RL7 RL8
      else $error("override level wrong on output A");

   property p_disabled_no_drive;
      @(posedge sys_clk_i) disable iff (!rst_n)
      !en_reg |-> (wave_oe_o == 4'h0);
   endproperty
   a_disabled_no_drive: assert property (p_disabled_no_drive) // RL13
      else $error("outputs driven while disabled");

endmodule

// >>> verilog/wgs_pkg.sv
// Package for the waveform generator shutdown control block.
// Assumes an 8-bit register port with a 4-bit address.
package wgs_pkg;

   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [3:0] ADDR_CTRL_ZERO = 4'h0;
   localparam logic [3:0] ADDR_POLARITY  = 4'h1;
   localparam logic [3:0] ADDR_SD_CTRL   = 4'h2;
   localparam logic [3:0] ADDR_SD_SRC    = 4'h3;
   localparam logic [3:0] ADDR_DB_RISE   = 4'h4;
   localparam logic [3:0] ADDR_DB_FALL   = 4'h5;
   localparam logic [3:0] ADDR_OUT_EN    = 4'h6;
   localparam logic [3:0] ADDR_CLK_SEL   = 4'h7;

   // ****************************************
   // Field positions and reset values
   // ****************************************
   localparam int         CTRL_EN_BIT    = 7;
   localparam int         CTRL_LD_BIT    = 6;
   localparam int         POL_IN_BIT     = 5;
   localparam int         SD_BIT         = 7;
   localparam int         NUM_OUT        = 4;
   localparam int         NUM_SRC        = 4;
   localparam int         DB_WIDTH       = 6;
   localparam logic [7:0] RESET_BYTE     = 8'h00;
   localparam logic [7:0] UNMAPPED_READ  = 8'h00;

   // ****************************************
   // Output mode codes
   // ****************************************
   localparam logic [2:0] MODE_STEER      = 3'h0;
   localparam logic [2:0] MODE_SYNC_STEER = 3'h1;
   localparam logic [2:0] MODE_FWD_FULL   = 3'h2;
   localparam logic [2:0] MODE_REV_FULL   = 3'h3;
   localparam logic [2:0] MODE_HALF       = 3'h4;
   localparam logic [2:0] MODE_PUSH_PULL  = 3'h5;

   // Shutdown control register layout
   typedef struct packed {
      logic       shutdown;
      logic       auto_restart;
      logic [1:0] override_level_b_d;
      logic [1:0] override_level_a_c;
      logic [1:0] unused;
   } wgs_sd_ctrl_type;

   // Shutdown source register layout
   typedef struct packed {
      logic [NUM_OUT-1:0] affected;
      logic [NUM_SRC-1:0] source_sel;
   } wgs_sd_src_type;

endpackage

// >>> verilog/wgs_sync.sv
// Two-stage synchroniser for pin-level inputs.
// Assumes a single clock and an active-low reset already synchronised.
`timescale 1ns/1ns
module wgs_sync #(
   parameter int            WIDTH    = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input  wire logic             clk_i,
   input  wire logic             rst_n_i,
   input  wire logic [WIDTH-1:0] d_i,
   output logic      [WIDTH-1:0] q_o
);

   logic [WIDTH-1:0] stage1_reg;
   logic [WIDTH-1:0] stage1_next;
   logic [WIDTH-1:0] stage2_reg;
   logic [WIDTH-1:0] stage2_next;

   always_comb begin
      stage1_next = d_i;
      stage2_next = stage1_reg;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         stage1_reg <= RST_VAL;
         stage2_reg <= RST_VAL;
      end else begin
         stage1_reg <= stage1_next;
         stage2_reg <= stage2_next;
      end
   end

   assign q_o = stage2_reg;

endmodule
